// [gpan_chk.sv]
// gpan_chk: concurrent checks on the management port between host and pcs
// assumes the bench hands over the interface signals, one clock, async low reset
`timescale 1ns/1ns
`default_nettype none
module gpan_chk (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic req,
  input wire logic we,
  input wire logic [gpan_pkg::AW-1:0] addr,
  input wire logic [gpan_pkg::DW-1:0] wdata,
  input wire logic ack,
  input wire logic [gpan_pkg::DW-1:0] rdata
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // qualified strobes; we and addr stay put through the answer cycle
  logic rd_ack;
  logic wr_req;
  logic rd_req;
  assign rd_ack = ack && !we;
  assign wr_req = req && we;
  assign rd_req = req && !we;

  property p_ack_next;
    req |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");

  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");

  // one outstanding request, so no two in adjacent cycles
  property p_spacing;
    req |=> !req;
  endproperty
  a_spacing: assert property (p_spacing) else $error("requests too close");

  property p_restart_ro;
    rd_ack && addr == gpan_pkg::REG_CTRL |-> !rdata[gpan_pkg::CTRL_RESTART_BIT];
  endproperty
  a_restart_ro: assert property (p_restart_ro) else $error("restart bit read back as one");

  property p_restart_en;
    wr_req && addr == gpan_pkg::REG_CTRL && wdata[gpan_pkg::CTRL_RESTART_BIT]
      |-> wdata == 16'h1200;
  endproperty
  a_restart_en: assert property (p_restart_en) else $error("restart written without enable");

  // host issues at most one request every three cycles: req, ack, advance, next req
  property p_np_poll;
    wr_req && addr == gpan_pkg::REG_LNP |-> ##3 (rd_req && addr == gpan_pkg::REG_EXP);
  endproperty
  a_np_poll: assert property (p_np_poll) else $error("next page write not followed by poll");

  property p_complete_base;
    rd_ack && addr == gpan_pkg::REG_CTRL && rdata[gpan_pkg::CTRL_COMPLETE_BIT]
      |-> ##2 (rd_req && addr == gpan_pkg::REG_PBASE);
  endproperty
  a_complete_base: assert property (p_complete_base) else $error("complete seen, no base read");

  property p_pr_read;
    rd_ack && addr == gpan_pkg::REG_EXP && rdata[gpan_pkg::EXP_PR_BIT]
      |-> ##2 (rd_req && (addr == gpan_pkg::REG_PBASE || addr == gpan_pkg::REG_PNP));
  endproperty
  a_pr_read: assert property (p_pr_read) else $error("page received, no page read");

  // the resolve step may take a cycle, so allow a short window
  property p_np_end;
    rd_ack && addr == gpan_pkg::REG_PNP && !rdata[gpan_pkg::PAGE_NP_BIT]
      |-> ##[1:3] (wr_req && addr == gpan_pkg::REG_CTRL);
  endproperty
  a_np_end: assert property (p_np_end) else $error("exchange did not end");

  property p_np_more;
    rd_ack && addr == gpan_pkg::REG_PNP && rdata[gpan_pkg::PAGE_NP_BIT]
      && rdata != gpan_pkg::NULL_NEXT_PAGE |-> ##2 (wr_req && addr == gpan_pkg::REG_LNP);
  endproperty
  a_np_more: assert property (p_np_more) else $error("exchange stopped early");

  c_restart: cover property (wr_req && addr == gpan_pkg::REG_CTRL && wdata == 16'h1200);
  c_lnp: cover property (wr_req && addr == gpan_pkg::REG_LNP);
  c_pnp_end: cover property (rd_ack && addr == gpan_pkg::REG_PNP);
endmodule // gpan_chk
`default_nettype wire

// [gpan_device.sv]
// gpan_device: pcs management registers and the page exchange with the partner
// assumes partner pages arrive as same-clock pulses from the ten-bit receive path
`timescale 1ns/1ns
`default_nettype none
module gpan_device (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  gpan_mgmt_if.device mgmt,
  input wire logic [gpan_pkg::DW-1:0] partner_page_i,
  input wire logic partner_page_valid_i,
  output logic [gpan_pkg::DW-1:0] tx_page_o,
  output logic tx_page_valid_o,
  output logic duplex_led_pin_n_o
);
  typedef struct packed {
    gpan_pkg::gpan_dev_state_t state;
    logic an_en;
    logic duplex;
    logic complete;
    logic pr;
    logic [gpan_pkg::DW-1:0] adv;
    logic [gpan_pkg::DW-1:0] pbase;
    logic [gpan_pkg::DW-1:0] lnp;
    logic lnp_new;
    logic [gpan_pkg::DW-1:0] pnp;
    logic ack;
    logic [gpan_pkg::DW-1:0] rdata;
    logic [gpan_pkg::DW-1:0] tx_page;
    logic tx_valid;
    logic led_n;
  } gpan_dev_t;

  gpan_dev_t s;
  gpan_dev_t next_s;

  // read mux; restart always reads back zero
  function automatic logic [gpan_pkg::DW-1:0] rd_mux(input logic [gpan_pkg::AW-1:0] a,
                                                     input gpan_dev_t r);
    logic [gpan_pkg::DW-1:0] v;
    v = 16'h0000;
    case (a)
      gpan_pkg::REG_CTRL: begin
        v[gpan_pkg::CTRL_AN_EN_BIT] = r.an_en;
        v[gpan_pkg::CTRL_DUPLEX_BIT] = r.duplex;
        v[gpan_pkg::CTRL_COMPLETE_BIT] = r.complete;
      end
      gpan_pkg::REG_ADV: v = r.adv;
      gpan_pkg::REG_PBASE: v = r.pbase;
      gpan_pkg::REG_EXP: v[gpan_pkg::EXP_PR_BIT] = r.pr;
      gpan_pkg::REG_LNP: v = r.lnp;
      gpan_pkg::REG_PNP: v = r.pnp;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // page exchange first, then register access; restart overrides the exchange
  always_comb begin
    logic pr_set;
    pr_set = 1'b0;
    next_s = s;
    next_s.ack = 1'b0;
    case (s.state)
      gpan_pkg::GPAN_D_IDLE: begin
        next_s.tx_valid = 1'b0;
      end
      gpan_pkg::GPAN_D_BASE: begin
        next_s.tx_page = s.adv;
        next_s.tx_valid = 1'b1;
        if (partner_page_valid_i) begin
          next_s.pbase = partner_page_i;
          pr_set = 1'b1;
          // next pages only when both sides asked for them
          if (partner_page_i[gpan_pkg::PAGE_NP_BIT] && s.adv[gpan_pkg::PAGE_NP_BIT]) begin
            next_s.state = gpan_pkg::GPAN_D_NP_WAIT;
          end else begin
            next_s.state = gpan_pkg::GPAN_D_DONE;
          end
        end
      end
      gpan_pkg::GPAN_D_NP_WAIT: begin
        // keep sending the last page until software supplies a new one
        if (s.lnp_new) begin
          next_s.tx_page = s.lnp;
          next_s.lnp_new = 1'b0;
          next_s.state = gpan_pkg::GPAN_D_NP_TX;
        end
      end
      gpan_pkg::GPAN_D_NP_TX: begin
        if (partner_page_valid_i) begin
          next_s.pnp = partner_page_i;
          pr_set = 1'b1;
          if (!partner_page_i[gpan_pkg::PAGE_NP_BIT]) begin
            next_s.state = gpan_pkg::GPAN_D_DONE;
          end else begin
            next_s.state = gpan_pkg::GPAN_D_NP_WAIT;
          end
        end
      end
      gpan_pkg::GPAN_D_DONE: begin
        next_s.complete = 1'b1;
      end
      default: next_s.state = gpan_pkg::GPAN_D_IDLE;
    endcase
    if (pr_set) begin
      next_s.pr = 1'b1;
    end
    // all negotiation control goes through these registers
    if (mgmt.req) begin
      next_s.ack = 1'b1;
      next_s.rdata = rd_mux(mgmt.addr, s);
      if (mgmt.we) begin
        case (mgmt.addr)
          gpan_pkg::REG_CTRL: begin
            next_s.an_en = mgmt.wdata[gpan_pkg::CTRL_AN_EN_BIT];
            next_s.duplex = mgmt.wdata[gpan_pkg::CTRL_DUPLEX_BIT];
            if (!mgmt.wdata[gpan_pkg::CTRL_AN_EN_BIT]) begin
              next_s.state = gpan_pkg::GPAN_D_IDLE;
              next_s.complete = 1'b0;
            end else if (mgmt.wdata[gpan_pkg::CTRL_RESTART_BIT]) begin
              next_s.state = gpan_pkg::GPAN_D_BASE;
              next_s.complete = 1'b0;
              next_s.pr = 1'b0;
              next_s.lnp_new = 1'b0;
            end
          end
          gpan_pkg::REG_ADV: next_s.adv = mgmt.wdata;
          gpan_pkg::REG_LNP: begin
            next_s.lnp = mgmt.wdata;
            next_s.lnp_new = 1'b1;
          end
          default: next_s.adv = next_s.adv; // read-only or unmapped: ignored
        endcase
      end else if (mgmt.addr == gpan_pkg::REG_EXP && !pr_set) begin
        next_s.pr = 1'b0;
      end
    end
    // besides the control register read-back, the led is the only user of the duplex bit
    next_s.led_n = ~next_s.duplex;
  end

  // pcs register state; coding and sync machines sit outside this block
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '{state: gpan_pkg::GPAN_D_IDLE, an_en: gpan_pkg::RST_AN_EN,
             duplex: gpan_pkg::RST_DUPLEX, complete: 1'b0, pr: 1'b0,
             adv: gpan_pkg::RST_ADV, pbase: gpan_pkg::RST_PAGE,
             lnp: gpan_pkg::RST_PAGE, lnp_new: 1'b0, pnp: gpan_pkg::RST_PAGE,
             ack: 1'b0, rdata: gpan_pkg::RST_PAGE, tx_page: gpan_pkg::RST_PAGE,
             tx_valid: 1'b0, led_n: ~gpan_pkg::RST_DUPLEX};
    end else begin
      s <= next_s;
    end
  end

  assign mgmt.ack = s.ack;
  assign mgmt.rdata = s.rdata;
  assign tx_page_o = s.tx_page;
  assign tx_page_valid_o = s.tx_valid;
  assign duplex_led_pin_n_o = s.led_n;
endmodule // gpan_device
`default_nettype wire

// [gpan_host.sv]
// gpan_host: host-side sequencer that drives negotiation over the management port
// assumes the pcs answers each request with an ack one cycle later
`timescale 1ns/1ns
`default_nettype none
module gpan_host (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  gpan_mgmt_if.host mgmt,
  input wire logic start_i,
  input wire logic an_enable_i,
  input wire logic [gpan_pkg::DW-1:0] adv_ability_i,
  input wire logic np_valid_i,
  input wire logic [gpan_pkg::DW-1:0] np_data_i,
  output logic np_ready_o,
  output logic done_o,
  output logic [gpan_pkg::DW-1:0] partner_base_o,
  output logic partner_ack2_o,
  output logic mac_duplex_select_bit_o,
  output logic receive_flow_control_bit_o,
  output logic pause_tx_enable_o,
  output logic [gpan_pkg::DW-1:0] np_feature_o
);
  typedef struct packed {
    gpan_pkg::gpan_host_state_t state;
    logic busy;
    logic req;
    logic we;
    logic [gpan_pkg::AW-1:0] addr;
    logic [gpan_pkg::DW-1:0] wdata;
    logic en;
    logic [gpan_pkg::DW-1:0] adv;
    logic [gpan_pkg::DW-1:0] pbase;
    logic [gpan_pkg::DW-1:0] pnp;
    logic np_ready;
    logic done;
    logic ack2;
    logic full;
    logic rx_fc;
    logic tx_pause;
    logic [gpan_pkg::DW-1:0] feat;
  } gpan_host_rec_t;

  gpan_host_rec_t s;
  gpan_host_rec_t next_s;

  // per-state access is picked first, then issued by one shared path,
  // so every register access follows the same req/ack handshake
  always_comb begin
    logic op;
    logic op_we;
    logic [gpan_pkg::AW-1:0] op_addr;
    logic [gpan_pkg::DW-1:0] op_wdata;
    logic l_p;
    logic l_a;
    logic p_p;
    logic p_a;
    op = 1'b0;
    op_we = 1'b0;
    op_addr = gpan_pkg::REG_CTRL;
    op_wdata = 16'h0000;
    l_p = s.adv[gpan_pkg::ABIL_PAUSE_BIT];
    l_a = s.adv[gpan_pkg::ABIL_ASM_BIT];
    p_p = s.pbase[gpan_pkg::ABIL_PAUSE_BIT];
    p_a = s.pbase[gpan_pkg::ABIL_ASM_BIT];
    next_s = s;
    next_s.req = 1'b0;
    next_s.np_ready = 1'b0;
    // choose the access of this state
    case (s.state)
      gpan_pkg::GPAN_H_IDLE: begin
        if (start_i) begin
          next_s.adv = adv_ability_i;
          next_s.en = an_enable_i;
          next_s.done = 1'b0;
          next_s.state = gpan_pkg::GPAN_H_EN;
        end
      end
      gpan_pkg::GPAN_H_EN: begin
        op = 1'b1;
        op_we = 1'b1;
        op_wdata[gpan_pkg::CTRL_AN_EN_BIT] = s.en;
      end
      gpan_pkg::GPAN_H_ADV: begin
        op = 1'b1;
        op_we = 1'b1;
        op_addr = gpan_pkg::REG_ADV;
        op_wdata = s.adv;
      end
      gpan_pkg::GPAN_H_RESTART: begin
        op = 1'b1;
        op_we = 1'b1;
        op_wdata[gpan_pkg::CTRL_AN_EN_BIT] = 1'b1;
        op_wdata[gpan_pkg::CTRL_RESTART_BIT] = 1'b1;
      end
      gpan_pkg::GPAN_H_POLL_BASE: begin
        op = 1'b1;
        // page received only matters when next pages follow
        op_addr = s.adv[gpan_pkg::PAGE_NP_BIT] ? gpan_pkg::REG_EXP : gpan_pkg::REG_CTRL;
      end
      gpan_pkg::GPAN_H_RD_BASE: begin
        op = 1'b1;
        op_addr = gpan_pkg::REG_PBASE;
      end
      gpan_pkg::GPAN_H_WR_NP: begin
        op = 1'b1;
        op_we = 1'b1;
        op_addr = gpan_pkg::REG_LNP;
        op_wdata = np_valid_i ? np_data_i : gpan_pkg::NULL_NEXT_PAGE;
      end
      gpan_pkg::GPAN_H_POLL_NP: begin
        op = 1'b1;
        op_addr = gpan_pkg::REG_EXP;
      end
      gpan_pkg::GPAN_H_RD_NP: begin
        op = 1'b1;
        op_addr = gpan_pkg::REG_PNP;
      end
      gpan_pkg::GPAN_H_RESOLVE: begin
        // priority resolution is done here, not in the pcs
        next_s.full = s.adv[gpan_pkg::ABIL_FD_BIT] & s.pbase[gpan_pkg::ABIL_FD_BIT];
        if (l_p && p_p) begin
          next_s.tx_pause = 1'b1;
          next_s.rx_fc = 1'b1;
        end else begin
          next_s.tx_pause = !l_p && l_a && p_p && p_a;
          next_s.rx_fc = l_p && l_a && !p_p && p_a;
        end
        next_s.state = gpan_pkg::GPAN_H_WR_DPLX;
      end
      gpan_pkg::GPAN_H_WR_DPLX: begin
        op = 1'b1;
        op_we = 1'b1;
        op_wdata[gpan_pkg::CTRL_AN_EN_BIT] = s.en;
        op_wdata[gpan_pkg::CTRL_DUPLEX_BIT] = s.full;
      end
      default: next_s.state = gpan_pkg::GPAN_H_IDLE;
    endcase
    // shared issue path; a new request only after the previous ack
    if (op && !s.busy) begin
      next_s.req = 1'b1;
      next_s.busy = 1'b1;
      next_s.we = op_we;
      next_s.addr = op_addr;
      next_s.wdata = op_wdata;
      if (s.state == gpan_pkg::GPAN_H_WR_NP && np_valid_i) begin
        next_s.np_ready = 1'b1; // page taken from the user queue
      end
    end else if (op && mgmt.ack) begin
      next_s.busy = 1'b0;
      // advance on the answer
      case (s.state)
        gpan_pkg::GPAN_H_EN: begin
          next_s.state = s.en ? gpan_pkg::GPAN_H_ADV : gpan_pkg::GPAN_H_IDLE;
          next_s.done = !s.en;
        end
        gpan_pkg::GPAN_H_ADV: next_s.state = gpan_pkg::GPAN_H_RESTART;
        gpan_pkg::GPAN_H_RESTART: next_s.state = gpan_pkg::GPAN_H_POLL_BASE;
        gpan_pkg::GPAN_H_POLL_BASE: begin
          if (s.adv[gpan_pkg::PAGE_NP_BIT] ? mgmt.rdata[gpan_pkg::EXP_PR_BIT]
                                           : mgmt.rdata[gpan_pkg::CTRL_COMPLETE_BIT]) begin
            next_s.state = gpan_pkg::GPAN_H_RD_BASE;
          end
        end
        gpan_pkg::GPAN_H_RD_BASE: begin
          next_s.pbase = mgmt.rdata;
          if (mgmt.rdata[gpan_pkg::PAGE_NP_BIT] && s.adv[gpan_pkg::PAGE_NP_BIT]) begin
            next_s.state = gpan_pkg::GPAN_H_WR_NP;
          end else begin
            next_s.state = gpan_pkg::GPAN_H_RESOLVE;
          end
        end
        gpan_pkg::GPAN_H_WR_NP: next_s.state = gpan_pkg::GPAN_H_POLL_NP;
        gpan_pkg::GPAN_H_POLL_NP: begin
          if (mgmt.rdata[gpan_pkg::EXP_PR_BIT]) begin
            next_s.state = gpan_pkg::GPAN_H_RD_NP;
          end
        end
        gpan_pkg::GPAN_H_RD_NP: begin
          next_s.pnp = mgmt.rdata;
          next_s.ack2 = mgmt.rdata[gpan_pkg::PAGE_ACK2_BIT];
          if (!mgmt.rdata[gpan_pkg::PAGE_NP_BIT] ||
              (mgmt.rdata == gpan_pkg::NULL_NEXT_PAGE && !np_valid_i)) begin
            next_s.state = gpan_pkg::GPAN_H_RESOLVE;
          end else begin
            next_s.state = gpan_pkg::GPAN_H_WR_NP;
          end
        end
        gpan_pkg::GPAN_H_WR_DPLX: begin
          // agreed next-page message is handed on last
          next_s.feat = s.pnp;
          next_s.done = 1'b1;
          next_s.state = gpan_pkg::GPAN_H_IDLE;
        end
        default: next_s.state = gpan_pkg::GPAN_H_IDLE;
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '{state: gpan_pkg::GPAN_H_IDLE, busy: 1'b0, req: 1'b0, we: 1'b0,
             addr: gpan_pkg::REG_CTRL, wdata: gpan_pkg::RST_PAGE, en: 1'b0,
             adv: gpan_pkg::RST_PAGE, pbase: gpan_pkg::RST_PAGE,
             pnp: gpan_pkg::RST_PAGE, np_ready: 1'b0, done: 1'b0, ack2: 1'b0,
             full: 1'b0, rx_fc: 1'b0, tx_pause: 1'b0, feat: gpan_pkg::RST_PAGE};
    end else begin
      s <= next_s;
    end
  end

  assign mgmt.req = s.req;
  assign mgmt.we = s.we;
  assign mgmt.addr = s.addr;
  assign mgmt.wdata = s.wdata;
  assign np_ready_o = s.np_ready;
  assign done_o = s.done;
  assign partner_base_o = s.pbase;
  assign partner_ack2_o = s.ack2;
  assign mac_duplex_select_bit_o = s.full;
  assign receive_flow_control_bit_o = s.rx_fc;
  // pause transmit is never driven by the pcs, only by this output
  assign pause_tx_enable_o = s.tx_pause;
  assign np_feature_o = s.feat;
endmodule // gpan_host
`default_nettype wire

// [gpan_mgmt_if.sv]
// gpan_mgmt_if: management register port between host logic and the pcs
// assumes both ends run on the same clock; request is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface gpan_mgmt_if;
  logic req;
  logic we;
  logic [gpan_pkg::AW-1:0] addr;
  logic [gpan_pkg::DW-1:0] wdata;
  logic ack;
  logic [gpan_pkg::DW-1:0] rdata;
  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// [gpan_pcs_autoneg_sequence_bench.sv]
// gpan_pcs_autoneg_sequence_bench: host and pcs joined, partner pages played by the bench
// assumes design inputs change on the falling edge; all waits are bounded
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  compares++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
  end
module gpan_pcs_autoneg_sequence_bench;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start = 1'b0;
  logic an_en = 1'b1;
  logic np_vld = 1'b0;
  logic page_vld = 1'b0;
  logic [15:0] adv = 16'h0000;
  logic [15:0] np_data = 16'h0000;
  logic [15:0] page = 16'h0000;
  logic np_ready, done, ack2, dup, rxfc, txp, tx_vld, led_n;
  logic [15:0] pbase, feat, tx_page;
  int error_cnt = 0;
  int compares = 0;
  int pops = 0;
  // rows: local pause/asm/fd, partner pause/asm/fd, expected duplex/rx/tx
  localparam logic [8:0] ROWS [9] = '{9'h07C, 9'h1E3, 9'h0D0, 9'h0A8, 9'h0FD,
                                      9'h110, 9'h16F, 9'h180, 9'h1DE};
  logic [8:0] r;
  logic [15:0] a, p;

  always #10 ref_clk_i = ~ref_clk_i;

  // count popped user pages mid-cycle, while the one-cycle pulse stands
  always @(negedge ref_clk_i) begin
    if (np_ready === 1'b1) begin
      pops++;
    end
  end

  gpan_mgmt_if gpan_mgmt_if_i ();
  gpan_device gpan_device_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .mgmt(gpan_mgmt_if_i),
    .partner_page_i(page), .partner_page_valid_i(page_vld), .tx_page_o(tx_page),
    .tx_page_valid_o(tx_vld), .duplex_led_pin_n_o(led_n));
  gpan_host gpan_host_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .mgmt(gpan_mgmt_if_i),
    .start_i(start), .an_enable_i(an_en), .adv_ability_i(adv), .np_valid_i(np_vld),
    .np_data_i(np_data), .np_ready_o(np_ready), .done_o(done), .partner_base_o(pbase),
    .partner_ack2_o(ack2), .mac_duplex_select_bit_o(dup), .receive_flow_control_bit_o(rxfc),
    .pause_tx_enable_o(txp), .np_feature_o(feat));
  gpan_chk gpan_chk_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req(gpan_mgmt_if_i.req),
    .we(gpan_mgmt_if_i.we), .addr(gpan_mgmt_if_i.addr), .wdata(gpan_mgmt_if_i.wdata),
    .ack(gpan_mgmt_if_i.ack), .rdata(gpan_mgmt_if_i.rdata));

  task end_of_test;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a wait that runs out counts as a mismatch and closes the run
  task timeout(input string what);
    error_cnt++;
    $display("MISMATCH %s expected %h seen %h", what, 1'b1, 1'b0);
    end_of_test;
  endtask

  // start pulse, then for enabled runs wait for the restart write on the port
  task start_run(input logic en, input logic [15:0] ab);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    an_en = en;
    adv = ab;
    start = 1'b1;
    @(negedge ref_clk_i);
    start = 1'b0;
    while (en && !(gpan_mgmt_if_i.req === 1'b1 && gpan_mgmt_if_i.we === 1'b1
           && gpan_mgmt_if_i.wdata[gpan_pkg::CTRL_RESTART_BIT] === 1'b1) && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 100) timeout("restart_write");
    @(negedge ref_clk_i);
  endtask

  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 400) timeout("done");
  endtask

  task wait_page(input logic [15:0] v);
    int n;
    n = 0;
    while (!(tx_vld === 1'b1 && tx_page === v) && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 400) timeout("tx_page");
  endtask

  // one-cycle partner page; afterwards the line shows the inverse, not stale data
  task send_page(input logic [15:0] v);
    page = v;
    page_vld = 1'b1;
    @(negedge ref_clk_i);
    page_vld = 1'b0;
    page = ~v;
  endtask

  task check_reset;
    `CHK("done_rst", 1'b0, done);
    `CHK("tx_vld_rst", 1'b0, tx_vld);
    `CHK("led_rst", 1'b1, led_n);
    `CHK("dup_rst", 1'b0, dup);
  endtask

  initial begin
    repeat (2) @(negedge ref_clk_i);
    check_reset;
    rst_b_i = 1'b1;
    $display("test reset done");
    // plain negotiations without next pages, one per row
    for (int i = 0; i < 9; i++) begin
      r = ROWS[i];
      a = 16'h0000;
      p = 16'h0000;
      {a[gpan_pkg::ABIL_PAUSE_BIT], a[gpan_pkg::ABIL_ASM_BIT], a[gpan_pkg::ABIL_FD_BIT]} = r[8:6];
      {p[gpan_pkg::ABIL_PAUSE_BIT], p[gpan_pkg::ABIL_ASM_BIT], p[gpan_pkg::ABIL_FD_BIT]} = r[5:3];
      start_run(1'b1, a);
      wait_page(a);
      send_page(p);
      wait_done;
      `CHK("adv_page", a, tx_page);
      `CHK("pbase", p, pbase);
      `CHK("duplex", r[2], dup);
      `CHK("rx_fc", r[1], rxfc);
      `CHK("pause_tx", r[0], txp);
      `CHK("led", ~r[2], led_n);
      $display("test row %0d done", i);
    end
    // next-page exchange: one user page, then a null page, partner ends it
    np_data = 16'h1005;
    np_vld = 1'b1;
    start_run(1'b1, 16'h8020);
    wait_page(16'h8020);
    send_page(16'h80A0);
    wait_page(16'h1005);
    np_vld = 1'b0;
    send_page(16'h9123);
    `CHK("np_first", 16'h1005, tx_page);
    wait_page(16'h2001);
    send_page(16'h1456);
    `CHK("np_null", gpan_pkg::NULL_NEXT_PAGE, tx_page);
    wait_done;
    `CHK("np_pops", 1, pops);
    `CHK("np_pbase", 16'h80A0, pbase);
    `CHK("np_ack2", 1'b1, ack2);
    `CHK("np_feature", 16'h1456, feat);
    `CHK("np_duplex", 1'b1, dup);
    `CHK("np_rx_fc", 1'b0, rxfc);
    $display("test next_page done");
    // negotiation switched off: no page is advertised
    start_run(1'b0, 16'h0020);
    wait_done;
    `CHK("off_tx_vld", 1'b0, tx_vld);
    $display("test disable done");
    // reset in mid-negotiation
    start_run(1'b1, 16'h0020);
    wait_page(16'h0020);
    rst_b_i = 1'b0;
    @(negedge ref_clk_i);
    check_reset;
    rst_b_i = 1'b1;
    @(negedge ref_clk_i);
    $display("test mid_reset done");
    end_of_test;
  end
endmodule // gpan_pcs_autoneg_sequence_bench
`default_nettype wire

// [gpan_pkg.sv]
// gpan_pkg: constants and state encodings for the pcs auto-negotiation pair
// assumes both ends share one clock and index the same six management registers
package gpan_pkg;
  localparam int DW = 16;
  localparam int AW = 3;
  // management register indices
  localparam logic [AW-1:0] REG_CTRL = 3'h0;
  localparam logic [AW-1:0] REG_ADV = 3'h1;
  localparam logic [AW-1:0] REG_PBASE = 3'h2;
  localparam logic [AW-1:0] REG_EXP = 3'h3;
  localparam logic [AW-1:0] REG_LNP = 3'h4;
  localparam logic [AW-1:0] REG_PNP = 3'h5;
  // control register fields
  localparam int CTRL_AN_EN_BIT = 12;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_COMPLETE_BIT = 5;
  // expansion register field
  localparam int EXP_PR_BIT = 1;
  // page fields, base and next pages
  localparam int PAGE_NP_BIT = 15;
  localparam int PAGE_ACK2_BIT = 12;
  localparam int ABIL_FD_BIT = 5;
  localparam int ABIL_PAUSE_BIT = 7;
  localparam int ABIL_ASM_BIT = 8;
  // null next page and reset values
  localparam logic [DW-1:0] NULL_NEXT_PAGE = 16'h2001;
  localparam logic RST_AN_EN = 1'b1;
  localparam logic RST_DUPLEX = 1'b0;
  localparam logic [DW-1:0] RST_ADV = 16'h0020;
  localparam logic [DW-1:0] RST_PAGE = 16'h0000;

  typedef enum logic [2:0] {
    GPAN_D_IDLE = 3'h0,
    GPAN_D_BASE = 3'h1,
    GPAN_D_NP_WAIT = 3'h2,
    GPAN_D_NP_TX = 3'h3,
    GPAN_D_DONE = 3'h4
  } gpan_dev_state_t;

  typedef enum logic [3:0] {
    GPAN_H_IDLE = 4'h0,
    GPAN_H_EN = 4'h1,
    GPAN_H_ADV = 4'h2,
    GPAN_H_RESTART = 4'h3,
    GPAN_H_POLL_BASE = 4'h4,
    GPAN_H_RD_BASE = 4'h5,
    GPAN_H_WR_NP = 4'h6,
    GPAN_H_POLL_NP = 4'h7,
    GPAN_H_RD_NP = 4'h8,
    GPAN_H_RESOLVE = 4'h9,
    GPAN_H_WR_DPLX = 4'hA
  } gpan_host_state_t;
endpackage
